// File: pkg/drc_params.svh
// constants for the memory configuration word block: fields, defaults, decodes
// assumes inclusion from the package and the bench only
`ifndef DRC_PARAMS_SVH
`define DRC_PARAMS_SVH

`define DRC_CFG_RST      16'h8F2F
`define DRC_CFG_SLEEP_B  15
`define DRC_CFG_DRV_HI   14
`define DRC_CFG_DRV_LO   12
`define DRC_CFG_LAT_HI   7
`define DRC_CFG_LAT_LO   4
`define DRC_CFG_FIXED_B  3
`define DRC_CFG_LEGACY_B 2
`define DRC_CFG_BL_HI    1
`define DRC_CFG_BL_LO    0

`define DRC_CA_BYTES     4'h6
`define DRC_CA_READ_B    47
`define DRC_CA_REGSP_B   46
`define DRC_CA_KIND_B    45
`define DRC_CA_DIE_B     35
`define DRC_CA_REGHI     8'h01
`define DRC_CA_REGLO     8'h00

`define DRC_LAT_5        4'h0
`define DRC_LAT_6        4'h1
`define DRC_LAT_7        4'h2
`define DRC_LAT_3        4'hE
`define DRC_LAT_4        4'hF

`endif

// File: pkg/drc_pkg.sv
// types of the memory configuration word block
// assumes drc_params.svh is on the include path
`default_nettype none
package drc_pkg;
  `include "drc_params.svh"

  typedef enum logic [2:0] {
    DRC_IDLE, DRC_CA, DRC_WDATA, DRC_LAT, DRC_RDATA, DRC_ARRAY, DRC_SKIP
  } drc_state_t;

  typedef struct packed {
    drc_state_t  st;
    logic [39:0] ca;
    logic [3:0]  cnt;
    logic [3:0]  lat;
    logic        dbl;
    logic [15:0] cfg;
    logic        sleep;
    logic [7:0]  wbyte;
    logic        is_rd;
    logic        regsp;
    logic        wrap;
    logic        hyb;
    logic [6:0]  wcnt;
    logic [6:0]  gmask;
    logic [7:0]  dq_o;
    logic        dq_oe_n;
    logic        rw_o;
    logic        rw_oe_n;
    logic [31:0] baddr;
    logic        bvalid;
    logic        bmask;
  } drc_regs_t;
endpackage : drc_pkg
`default_nettype wire

// File: rtl/drc_cfg_bank.sv
// configuration word zero of a self-refreshing ddr memory, with its bus side
// and the burst address ordering the word selects
// assumes one command/address or data byte per clk_in rising edge, inputs synchronous
`timescale 1ns/10ps
`default_nettype none
module drc_cfg_bank
  import drc_pkg::*;
#(
  parameter bit       STACKED = 1'b0,
  parameter bit       DIE_ID  = 1'b0
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // memory bus
  input  wire logic        cs_n_in,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  output logic             dq_oe_n_out,
  input  wire logic        strobe_mask_line_in,
  output logic             strobe_mask_line_out,
  output logic             strobe_mask_line_oe_n_out,
  // array side
  input  wire logic        refresh_due_in,
  output logic      [31:0] burst_addr_out,
  output logic             burst_valid_out,
  output logic             burst_mask_out,
  // configuration state
  output logic      [15:0] memory_config_word_zero_out,
  output logic             deep_sleep_state_out,
  output logic      [2:0]  drive_strength_out
);

  function automatic logic [3:0] lat_clocks(input logic [3:0] code);
    case (code)
      `DRC_LAT_5: lat_clocks = 4'h5;
      `DRC_LAT_6: lat_clocks = 4'h6;
      `DRC_LAT_7: lat_clocks = 4'h7;
      `DRC_LAT_3: lat_clocks = 4'h3;
      `DRC_LAT_4: lat_clocks = 4'h4;
      default:    lat_clocks = 4'h7;  // reserved codes run at the slowest setting
    endcase
  endfunction : lat_clocks

  function automatic logic [6:0] group_mask(input logic [1:0] bl);
    case (bl)
      2'h0:    group_mask = 7'h3F;
      2'h1:    group_mask = 7'h1F;
      2'h2:    group_mask = 7'h07;
      default: group_mask = 7'h0F;
    endcase
  endfunction : group_mask

  drc_regs_t r;
  drc_regs_t r_nxt;
  logic [47:0] ca_full;
  logic        ca_sel;
  logic        ca_cfg;
  logic        dbl_now;
  logic        cfg_wr;
  logic [15:0] cfg_wval;
  logic [3:0]  lat_tot;
  logic [31:0] gmask32;

  always_comb begin
    r_nxt    = r;
    ca_full  = {r.ca, dq_in};
    ca_sel   = !STACKED || (r.ca[`DRC_CA_DIE_B - 8] == DIE_ID);
    ca_cfg   = (r.ca[31:24] == `DRC_CA_REGHI) && (r.ca[7:0] == `DRC_CA_REGLO);
    // a stack always signals the extra latency
    dbl_now  = r.cfg[`DRC_CFG_FIXED_B] || STACKED || refresh_due_in;
    cfg_wval = {r.wbyte, dq_in};
    cfg_wr   = 1'b0;
    lat_tot  = lat_clocks(r.cfg[`DRC_CFG_LAT_HI:`DRC_CFG_LAT_LO]);
    gmask32  = {25'h0, r.gmask};
    r_nxt.bvalid  = 1'b0;
    r_nxt.bmask   = 1'b0;
    r_nxt.dq_oe_n = 1'b1;
    case (r.st)
      DRC_IDLE: begin
        r_nxt.rw_oe_n = 1'b1;
        if (!cs_n_in && r.sleep) begin
          r_nxt.sleep = 1'b0;
          r_nxt.cfg[`DRC_CFG_SLEEP_B] = 1'b1;
          r_nxt.st = DRC_SKIP;
        end else if (!cs_n_in) begin
          r_nxt.ca      = {32'h0, dq_in};
          r_nxt.cnt     = 4'h1;
          r_nxt.dbl     = dbl_now;
          r_nxt.rw_o    = dbl_now;
          r_nxt.rw_oe_n = 1'b0;
          r_nxt.st      = DRC_CA;
        end
      end
      DRC_CA: begin
        r_nxt.ca  = ca_full[39:0];
        r_nxt.cnt = r.cnt + 4'h1;
        if (r.cnt == `DRC_CA_BYTES - 4'h1) begin
          r_nxt.is_rd = ca_full[`DRC_CA_READ_B];
          // the space bit is shifted out of r.ca, so it is kept apart
          r_nxt.regsp = ca_full[`DRC_CA_REGSP_B];
          r_nxt.wrap  = !ca_full[`DRC_CA_KIND_B];
          r_nxt.hyb   = !ca_full[`DRC_CA_KIND_B] && !r.cfg[`DRC_CFG_LEGACY_B];
          r_nxt.gmask = group_mask(r.cfg[`DRC_CFG_BL_HI:`DRC_CFG_BL_LO]);
          r_nxt.baddr = {ca_full[44:16], ca_full[2:0]};
          r_nxt.wcnt  = 7'h0;
          r_nxt.lat   = r.dbl ? 4'((lat_tot << 1) - 4'h1) : 4'(lat_tot - 4'h1);
          r_nxt.rw_o  = 1'b0;
          if (!ca_sel) begin
            r_nxt.rw_oe_n = 1'b1;
            r_nxt.st = DRC_SKIP;
          end else if (ca_full[`DRC_CA_REGSP_B] && !ca_full[`DRC_CA_READ_B]) begin
            r_nxt.rw_oe_n = !STACKED;
            r_nxt.st = DRC_WDATA;
          end else begin
            r_nxt.rw_oe_n = !STACKED && !ca_full[`DRC_CA_READ_B];
            r_nxt.st = DRC_LAT;
          end
        end
      end
      DRC_WDATA: begin
        r_nxt.wbyte = dq_in;
        r_nxt.cnt   = r.cnt + 4'h1;
        if (r.cnt == `DRC_CA_BYTES + 4'h1) begin
          cfg_wr = ca_cfg;
          if (ca_cfg) begin
            r_nxt.cfg = cfg_wval;
            r_nxt.sleep = !cfg_wval[`DRC_CFG_SLEEP_B];
          end
          r_nxt.st = DRC_SKIP;
        end
      end
      DRC_LAT: begin
        r_nxt.lat = r.lat - 4'h1;
        if (r.lat == 4'h0) begin
          r_nxt.cnt = 4'h0;
          r_nxt.st  = r.regsp ? DRC_RDATA : DRC_ARRAY;
        end
      end
      DRC_RDATA: begin
        r_nxt.dq_oe_n = 1'b0;
        r_nxt.dq_o    = ca_cfg ? (r.cnt[0] ? r.cfg[7:0] : r.cfg[15:8]) : 8'h00;
        r_nxt.rw_o    = !r.cnt[0];
        r_nxt.rw_oe_n = 1'b0;
        r_nxt.cnt     = r.cnt + 4'h1;
        if (r.cnt[0]) begin
          r_nxt.st = DRC_SKIP;
        end
      end
      DRC_ARRAY: begin
        r_nxt.bvalid = 1'b1;
        r_nxt.bmask  = !r.is_rd && strobe_mask_line_in;
        if (r.is_rd) begin
          r_nxt.rw_o = !r.rw_o;
        end
        if (r.bvalid) begin
          if (r.wrap && !(r.hyb && r.wcnt > r.gmask)) begin
            r_nxt.wcnt = r.wcnt + 7'h1;
            if (r.hyb && r.wcnt == r.gmask) begin
              r_nxt.baddr = (r.baddr & ~gmask32) + gmask32 + 32'h1;
            end else begin
              r_nxt.baddr = (r.baddr & ~gmask32) | ((r.baddr + 32'h1) & gmask32);
            end
          end else begin
            r_nxt.baddr = r.baddr + 32'h1;
          end
        end
      end
      DRC_SKIP: begin
        if (!STACKED) begin
          r_nxt.rw_oe_n = 1'b1;
        end
      end
      default: r_nxt.st = DRC_IDLE;
    endcase
    if (cs_n_in && r.st != DRC_IDLE) begin
      r_nxt.st      = DRC_IDLE;
      r_nxt.rw_oe_n = 1'b1;
      r_nxt.dq_oe_n = 1'b1;
      r_nxt.bvalid  = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r         <= '0;
      r.st      <= DRC_IDLE;
      r.cfg     <= `DRC_CFG_RST;
      r.dq_oe_n <= 1'b1;
      r.rw_oe_n <= 1'b1;
    end else begin
      r <= r_nxt;
    end
  end

  assign dq_out                      = r.dq_o;
  assign dq_oe_n_out                 = r.dq_oe_n;
  assign strobe_mask_line_out        = r.rw_o;
  assign strobe_mask_line_oe_n_out   = r.rw_oe_n;
  assign burst_addr_out              = r.baddr;
  assign burst_valid_out             = r.bvalid;
  assign burst_mask_out              = r.bmask;
  assign memory_config_word_zero_out = r.cfg;
  assign deep_sleep_state_out        = r.sleep;
  assign drive_strength_out          = r.cfg[`DRC_CFG_DRV_HI:`DRC_CFG_DRV_LO];

  default clocking dcb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // edges spent in the latency wait, counted apart from the down-counter
  logic [4:0] lat_run_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lat_run_r <= 5'h00;
    end else if (r.st == DRC_LAT) begin
      lat_run_r <= lat_run_r + 5'h01;
    end else begin
      lat_run_r <= 5'h00;
    end
  end

  sequence wrap_end_s;
    burst_valid_out && r.hyb && r.wcnt == r.gmask;
  endsequence
  sequence next_group_s;
    burst_valid_out && r.wcnt > r.gmask;
  endsequence

  sleep_entry_a: assert property (
    cfg_wr && !cfg_wval[15] && !cs_n_in
    |=> deep_sleep_state_out && !memory_config_word_zero_out[15])
    else $error("sleep not entered");
  sleep_exit_a: assert property (
    deep_sleep_state_out && !cs_n_in
    |=> !deep_sleep_state_out && memory_config_word_zero_out[15])
    else $error("sleep not left");
  ca_fixed_a: assert property (
    r.st == DRC_CA && r.cfg[3] |-> strobe_mask_line_out && !strobe_mask_line_oe_n_out)
    else $error("fixed latency not signalled");
  ca_variable_a: assert property (
    $rose(r.st == DRC_CA) && !r.cfg[3]
    |-> strobe_mask_line_out == (STACKED || $past(refresh_due_in)))
    else $error("variable latency strobe wrong");
  lat_length_a: assert property (
    $fell(r.st == DRC_LAT) && r.st != DRC_IDLE && r.dbl && r.cfg[7:4] == 4'h2
    |-> lat_run_r == 5'h0E)
    else $error("latency length wrong");
  unsel_float_a: assert property (
    r.st == DRC_SKIP && $past(r.st) == DRC_CA |-> strobe_mask_line_oe_n_out)
    else $error("unselected die drives strobe");
  wrap_group_a: assert property (
    burst_valid_out && r.wrap && !r.hyb ##1 burst_valid_out
    |-> (burst_addr_out & ~{25'h0, r.gmask}) == ($past(burst_addr_out) & ~{25'h0, r.gmask}))
    else $error("wrap left group");
  hyb_next_a: assert property (
    wrap_end_s ##1 next_group_s |-> (burst_addr_out & {25'h0, r.gmask}) == 32'h0)
    else $error("hybrid not at next group start");
  reset_cfg_a: assert property (
    $rose(rst_n_in) |-> memory_config_word_zero_out == `DRC_CFG_RST)
    else $error("reset default missing");
endmodule : drc_cfg_bank
`default_nettype wire

// File: testbench/drc_cfg_bank_tb.sv
// self-checking bench for the configuration word block
// assumes a stacked neighbour die shares the bus, host model drives it
`timescale 1ns/10ps
`default_nettype none
`include "drc_params.svh"
module drc_cfg_bank_tb;
  import drc_pkg::*;
  logic        clk_in = 1'h0;
  logic        rst_n_in = 1'h0;
  logic        refresh_due_in = 1'h0;
  logic        cs_n_in, strobe_mask_line_in, dq_oe_n_out, strobe_mask_line_out;
  logic        strobe_mask_line_oe_n_out, burst_valid_out, burst_mask_out;
  logic        deep_sleep_state_out, s_stb, s_oe_n, ca_stb, ca_oe, ca_s2, ca_s2oe;
  logic        lat_stb, lat_oe, lat_s2oe;
  logic [7:0]  dq_in, dq_out;
  logic [2:0]  drive_strength_out;
  logic [15:0] memory_config_word_zero_out, d;
  logic [31:0] burst_addr_out;
  int          failures = 0;
  int          compares = 0;
  int          n0, n;
  logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h2, 4'hE, 4'hF, 4'h3};
  int          lats [6] = '{5, 6, 7, 3, 4, 7};
  int          grp [4] = '{64, 32, 8, 16};
  localparam logic [47:0] RD_CA = 48'hC000_0100_0000;

  always #5 clk_in = ~clk_in;

  drc_host_model host_u (.clk_in, .cs_n_out(cs_n_in), .dq_out(dq_in),
    .mask_out(strobe_mask_line_in));
  drc_cfg_bank dut_u (.clk_in, .rst_n_in, .cs_n_in, .dq_in, .dq_out, .dq_oe_n_out,
    .strobe_mask_line_in, .strobe_mask_line_out, .strobe_mask_line_oe_n_out,
    .refresh_due_in, .burst_addr_out, .burst_valid_out, .burst_mask_out,
    .memory_config_word_zero_out, .deep_sleep_state_out, .drive_strength_out);
  drc_cfg_bank #(.STACKED(1'b1), .DIE_ID(1'b1)) die1_u (.clk_in, .rst_n_in, .cs_n_in,
    .dq_in, .dq_out(), .dq_oe_n_out(), .strobe_mask_line_in,
    .strobe_mask_line_out(s_stb), .strobe_mask_line_oe_n_out(s_oe_n),
    .refresh_due_in, .burst_addr_out(), .burst_valid_out(), .burst_mask_out(),
    .memory_config_word_zero_out(), .deep_sleep_state_out(), .drive_strength_out());

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // latency counted in edges until read data is driven
  task automatic rd(output logic [15:0] dv, output int cnt);
    host_u.send(RD_CA);
    @(posedge clk_in);
    {ca_stb, ca_oe, ca_s2, ca_s2oe} = {strobe_mask_line_out,
      strobe_mask_line_oe_n_out, s_stb, s_oe_n};
    cnt = 1;
    while (dq_oe_n_out !== 1'h0 && cnt < 64) begin
      @(posedge clk_in);
      cnt++;
      if (cnt == 3)
        {lat_stb, lat_oe, lat_s2oe} = {strobe_mask_line_out,
          strobe_mask_line_oe_n_out, s_oe_n};
    end
    dv[15:8] = dq_out;
    @(posedge clk_in);
    dv[7:0] = dq_out;
    host_u.stop();
  endtask : rd

  // start word 3; hybrid goes linear from the next group base
  // write bursts expect the host mask on every beat
  task automatic burst(input logic kind, input int g, input logic hyb, input int cnt,
                       input logic wrb = 1'h0);
    int k;
    int e;
    host_u.send({~wrb, 1'b0, kind, 42'h0, 3'h3});
    k = 0;
    while (burst_valid_out !== 1'h1 && k < 64) begin
      @(posedge clk_in);
      k++;
    end
    for (int i = 0; i < cnt; i++) begin
      e = kind ? 3 + i : (hyb && i >= g) ? i : (3 + i) % g;
      chk("burst addr", e, burst_addr_out);
      chk("burst mask", wrb, burst_mask_out);
      @(posedge clk_in);
    end
    host_u.stop();
  endtask : burst

  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    #500_000;
    failures++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'h1;
    @(posedge clk_in);
    chk("reset cfg", `DRC_CFG_RST, memory_config_word_zero_out);
    rd(d, n0);
    chk("read cfg", `DRC_CFG_RST, d);
    chk("ca strobe", 2'h2, {ca_stb, ca_oe});
    chk("die1 ca strobe", 2'h2, {ca_s2, ca_s2oe});
    chk("after ca strobe", 3'h1, {lat_stb, lat_oe, lat_s2oe});
    foreach (codes[i]) begin
      host_u.wr({8'hDF, codes[i], 4'hF});
      chk("cfg", {8'hDF, codes[i], 4'hF}, memory_config_word_zero_out);
      chk("drive", 3'h5, drive_strength_out);
      rd(d, n);
      chk("latency", 2 * lats[i] - 14 + n0, n);
    end
    host_u.wr(16'h8F27);
    rd(d, n);
    chk("variable latency", n0 - 7, n);
    refresh_due_in <= 1'h1;
    rd(d, n);
    chk("refresh latency", n0, n);
    refresh_due_in <= 1'h0;
    for (int b = 0; b < 4; b++) begin
      host_u.wr(16'h8F28 | 16'(b));
      burst(1'h0, grp[b], 1'h1, grp[b] + 4);
    end
    burst(1'h1, 8, 1'h1, 12);
    host_u.wr(16'h8F2E);
    burst(1'h0, 8, 1'h0, 12);
    burst(1'h1, 8, 1'h0, 12);
    host_u.set_mask(1'h1);
    burst(1'h0, 8, 1'h0, 12, 1'h1);
    host_u.set_mask(1'h0);
    host_u.wr(16'h0F2F);
    chk("sleep", 1'h1, deep_sleep_state_out);
    host_u.wake();
    chk("wake", 2'h2, {memory_config_word_zero_out[15], deep_sleep_state_out});
    host_u.wr(16'hDF1E);
    chk("cfg before reset", 16'hDF1E, memory_config_word_zero_out);
    rst_n_in <= 1'h0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'h1;
    @(posedge clk_in);
    chk("reset again", `DRC_CFG_RST, memory_config_word_zero_out);
    test_done();
  end
endmodule : drc_cfg_bank_tb
`default_nettype wire

// File: testbench/drc_host_model.sv
// host controller model: sends command/address bytes and register words
// assumes the bench samples the device outputs itself
`timescale 1ns/10ps
`default_nettype none
module drc_host_model (
  // bus to the device
  input  wire logic       clk_in,
  output logic            cs_n_out,
  output logic      [7:0] dq_out,
  output logic            mask_out
);
  initial begin
    cs_n_out = 1'h1;
    dq_out   = 8'h00;
    mask_out = 1'h0;
  end
  task automatic send(input logic [47:0] ca);
    for (int i = 5; i >= 0; i--) begin
      @(posedge clk_in);
      cs_n_out <= 1'h0;
      dq_out   <= ca[i*8+:8];
    end
  endtask : send
  // released dq shows the inverse of the last byte
  task automatic stop();
    @(posedge clk_in);
    cs_n_out <= 1'h1;
    dq_out   <= ~dq_out;
    @(posedge clk_in);
  endtask : stop
  // single word, high byte ORed with 8'h0F, right after the command phase
  task automatic wr(input logic [15:0] d);
    send(48'h6000_0100_0000);
    @(posedge clk_in);
    dq_out <= d[15:8] | 8'h0F;
    @(posedge clk_in);
    dq_out <= d[7:0];
    stop();
  endtask : wr
  // write mask level for array write beats
  task automatic set_mask(input logic m);
    mask_out <= m;
  endtask : set_mask
  task automatic wake();
    @(posedge clk_in);
    cs_n_out <= 1'h0;
    stop();
  endtask : wake
endmodule : drc_host_model
`default_nettype wire
